// File: bench/adc_model.sv
module adc_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic conv_start,
   input wire logic [10:0] temp,
   input wire logic slow,
   output logic adc_done,
   output logic [10:0] adc_result
);
   timeunit 1ns;
   timeprecision 1ps;

   logic busy_reg;
   logic [2:0] wait_reg;
   logic [10:0] sample_reg;

   // ==========================================================
   // front end
   // temperature taken at the start, so a change mid-flight waits
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         busy_reg <= 1'b0;
         wait_reg <= 3'h0;
         adc_done <= 1'b0;
         sample_reg <= 11'h000;
      end else begin
         adc_done <= 1'b0;
         if (conv_start) begin
            busy_reg <= 1'b1;
            wait_reg <= slow ? 3'h6 : 3'h0;
            sample_reg <= temp;
         end else if (busy_reg && wait_reg == 3'h0) begin
            busy_reg <= 1'b0;
            adc_done <= 1'b1;
         end else if (busy_reg) begin
            wait_reg <= wait_reg - 3'h1;
         end
      end
   end

   // outside the done cycle the result is junk, never a stale match
   assign adc_result = adc_done ? sample_reg : ~sample_reg;
endmodule

// File: bench/test_thermal_watchdog.sv
module test_thermal_watchdog;
   timeunit 1ns;
   timeprecision 1ps;
   import thermal_pkg::*;

   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [2:0] addr_select = 3'h6;
   logic [1:0] reg_ptr = 2'h0;
   logic reg_wr = 1'b0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_rd = 1'b0;
   logic [10:0] model_temp = 11'h000;
   logic model_slow = 1'b0;
   wire [6:0] bus_address;
   wire [15:0] reg_rdata;
   wire reg_rvalid;
   wire conv_start;
   wire adc_done;
   wire [10:0] adc_result;
   wire alarm_o;
   wire alarm_oe;
   wire alarm_active;
   int fail_count = 0;
   int n_compared = 0;
   int k;
   int d;
   logic [15:0] rd_data;
   logic [15:0] reset_tbl [4] = '{16'h0000, 16'h0000, 16'h4B00, 16'h5000};
   int depth_tbl [4] = '{1, 2, 4, 6};

   always #2.5 clk = ~clk;

   thermal_watchdog #(.CONV_CYCLES(8)) u_dut (
      .clk(clk), .resetn(resetn), .addr_select(addr_select),
      .bus_address(bus_address), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .conv_start(conv_start),
      .adc_done(adc_done), .adc_result(adc_result),
      .alarm_output_o(alarm_o), .alarm_output_oe(alarm_oe),
      .alarm_active(alarm_active));

   adc_model u_adc (
      .clk(clk), .resetn(resetn), .conv_start(conv_start),
      .temp(model_temp), .slow(model_slow), .adc_done(adc_done),
      .adc_result(adc_result));

   // ==========================================================
   // helpers
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (fail_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [1:0] p, input logic [15:0] v);
      @(posedge clk);
      reg_ptr <= p;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // whole sixteen-bit word is collected in one read
   task automatic rd(input logic [1:0] p);
      @(posedge clk);
      reg_ptr <= p;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check("read valid", {15'h0, reg_rvalid}, 16'h0001);
      rd_data = reg_rdata;
   endtask

   task automatic wait_on(input bit pick);
      int n;
      n = 0;
      while ((pick ? adc_done : conv_start) !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 60) begin
            fail_count++;
            finish_test();
         end
      end
   endtask

   // one whole conversion with temperature t, alarm settled after it
   task automatic conv(input logic [10:0] t);
      @(posedge clk);
      model_temp <= t;
      #1;
      wait_on(1'b0);
      wait_on(1'b1);
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic chk_alarm(input logic act, input logic pol);
      check("alarm active", {15'h0, alarm_active}, {15'h0, act});
      check("alarm drive", {15'h0, alarm_oe}, {15'h0, act ^ pol});
      check("alarm value", {15'h0, alarm_o}, 16'h0000);
   endtask

   // ==========================================================
   // sequence
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      #1;
      check("address", {9'h0, bus_address}, 16'h002E);
      for (int i = 0; i < 4; i++) begin
         rd(i[1:0]);
         check("reset value", rd_data, reset_tbl[i]);
      end
      chk_alarm(1'b0, 1'b0);
      wr(PTR_SETUP, 16'hAAE0);
      rd(PTR_SETUP);
      check("setup", rd_data, 16'h00E0);
      wr(PTR_SETUP, 16'h0000);
      wr(PTR_HYST, 16'hFFFF);
      rd(PTR_HYST);
      check("hysteresis", rd_data, 16'hFF80);
      wr(PTR_HYST, 16'h4B00);
      wr(PTR_TEMP, 16'hFFFF);
      rd(PTR_TEMP);
      check("result write", rd_data, 16'h0000);
      model_slow <= 1'b1;
      conv(11'h7F9);
      rd(PTR_TEMP);
      check("result", rd_data, 16'hFF20);
      model_slow <= 1'b0;
      conv(11'h281);
      chk_alarm(1'b1, 1'b0);
      conv(11'h280);
      chk_alarm(1'b1, 1'b0);
      conv(11'h259);
      chk_alarm(1'b1, 1'b0);
      conv(11'h257);
      chk_alarm(1'b0, 1'b0);
      for (int c = 0; c < 4; c++) begin
         d = depth_tbl[c];
         wr(PTR_SETUP, {11'h0, c[1:0], 3'h0});
         k = 0;
         do begin
            conv(11'h300);
            k++;
         end while (alarm_active !== 1'b1 && k < 8);
         check("trip count", k[15:0], d[15:0]);
         k = 0;
         do begin
            conv(11'h100);
            k++;
         end while (alarm_active !== 1'b0 && k < 8);
         check("release count", k[15:0], d[15:0]);
      end
      wr(PTR_SETUP, 16'h0000);
      wr(PTR_OVER, 16'hFF00);
      conv(11'h7FC);
      chk_alarm(1'b1, 1'b0);
      wr(PTR_OVER, 16'h5000);
      conv(11'h000);
      chk_alarm(1'b0, 1'b0);
      wr(PTR_SETUP, 16'h0004);
      repeat (3) @(posedge clk);
      #1;
      chk_alarm(1'b0, 1'b1);
      conv(11'h300);
      chk_alarm(1'b1, 1'b1);
      conv(11'h100);
      wr(PTR_SETUP, 16'h0002);
      conv(11'h300);
      chk_alarm(1'b1, 1'b0);
      conv(11'h300);
      chk_alarm(1'b1, 1'b0);
      rd(PTR_HYST);
      repeat (3) @(posedge clk);
      #1;
      chk_alarm(1'b0, 1'b0);
      conv(11'h100);
      chk_alarm(1'b1, 1'b0);
      rd(PTR_TEMP);
      repeat (3) @(posedge clk);
      #1;
      chk_alarm(1'b0, 1'b0);
      wr(PTR_SETUP, 16'h0001);
      repeat (20) @(posedge clk);
      k = 0;
      repeat (40) begin
         @(posedge clk);
         #1;
         if (conv_start === 1'b1) k++;
      end
      check("starts in shutdown", k[15:0], 16'h0000);
      wr(PTR_HYST, 16'h1234);
      rd(PTR_HYST);
      check("hysteresis live", rd_data, 16'h1200);
      wr(PTR_SETUP, 16'h0000);
      wait_on(1'b0);
      @(posedge clk);
      resetn <= 1'b0;
      addr_select <= 3'h1;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      #1;
      check("address again", {9'h0, bus_address}, 16'h0029);
      rd(PTR_HYST);
      check("hysteresis reset", rd_data, 16'h4B00);
      chk_alarm(1'b0, 1'b0);
      finish_test();
   end
endmodule

// File: hdl/alarm_if.sv
// ==========================================================
// compare results into the fault queue and its verdict back
interface alarm_if;
   logic sample;
   logic over_limit;
   logic under_limit;
   logic [1:0] depth_code;
   logic tripped;
   logic changed;

   modport judge (
      output sample,
      output over_limit,
      output under_limit,
      output depth_code,
      input tripped,
      input changed
   );

   modport filter (
      input sample,
      input over_limit,
      input under_limit,
      input depth_code,
      output tripped,
      output changed
   );
endinterface

// File: hdl/alarm_queue.sv
module alarm_queue (
   input wire logic clk,
   input wire logic resetn,
   alarm_if.filter link
);
   import thermal_pkg::*;

   logic [2:0] count_reg;
   logic [2:0] count_next;
   logic trip_reg;
   logic changed_reg;

   wire [2:0] depth = queue_depth(link.depth_code);
   wire toward = trip_reg ? link.under_limit : link.over_limit;
   wire [2:0] count_inc = count_reg + 3'h1;
   wire flip = link.sample && toward && (count_inc >= depth);

   assign count_next = !link.sample ? count_reg :
                       (!toward || flip) ? 3'h0 : count_inc;
   assign link.tripped = trip_reg;
   assign link.changed = changed_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_reg <= 3'h0;
         trip_reg <= 1'b0;
         changed_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         trip_reg <= trip_reg ^ flip;
         changed_reg <= flip;
      end
   end

   AST_TRIP_ON_OVER: assert property (
      @(posedge clk) disable iff (!resetn)
      $rose(trip_reg) |-> $past(link.sample && link.over_limit))
      else $error("alarm tripped without an over-limit sample");

   AST_RELEASE_ON_UNDER: assert property (
      @(posedge clk) disable iff (!resetn)
      $fell(trip_reg) |-> $past(link.sample && link.under_limit))
      else $error("alarm released without an under-limit sample");

   AST_COUNT_BOUND: assert property (
      @(posedge clk) disable iff (!resetn)
      count_reg <= QUEUE_COUNT_MAX)
      else $error("fault queue count beyond deepest queue");
endmodule

// File: hdl/conv_sequencer.sv
module conv_sequencer #(
   parameter int unsigned PERIOD_CYCLES = thermal_pkg::CONV_PERIOD_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic shutdown,
   input wire logic adc_done,
   output logic conv_start,
   output logic conv_done
);
   import thermal_pkg::*;

   seq_state_t state_reg;
   seq_state_t state_next;
   logic [31:0] wait_reg;
   logic [31:0] wait_next;
   logic start_reg;

   wire period_end = (wait_reg == 32'(PERIOD_CYCLES - 1));
   // launch held in shutdown
   // shutdown blocks the launch and holds the period count at zero; a running conversion finishes
   wire launch = (state_reg == SEQ_WAIT) && period_end && !shutdown;

   assign wait_next = (launch || shutdown || state_reg == SEQ_BUSY) ?
                      32'h0 : wait_reg + 32'h1;
   assign conv_done = (state_reg == SEQ_BUSY) && adc_done;
   assign conv_start = start_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         SEQ_WAIT: if (launch) state_next = SEQ_BUSY;
         SEQ_BUSY: if (adc_done) state_next = SEQ_WAIT;
         default: state_next = SEQ_WAIT;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= SEQ_WAIT;
         wait_reg <= 32'h0;
         start_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         wait_reg <= wait_next;
         start_reg <= launch;
      end
   end

   AST_NO_START_IN_SHUTDOWN: assert property (
      @(posedge clk) disable iff (!resetn)
      conv_start |-> $past(!shutdown) ##1 !conv_start)
      else $error("conversion launched while shut down");
endmodule

// File: hdl/thermal_pkg.sv
package thermal_pkg;

   // ==========================================================
   // timing
   localparam int CLK_MHZ = 200;
   localparam int CONV_PERIOD_US = 100;
   localparam int CONV_PERIOD_CYCLES = CONV_PERIOD_US * CLK_MHZ;

   // ==========================================================
   // register pointers
   localparam logic [1:0] PTR_TEMP = 2'h0;
   localparam logic [1:0] PTR_SETUP = 2'h1;
   localparam logic [1:0] PTR_HYST = 2'h2;
   localparam logic [1:0] PTR_OVER = 2'h3;

   // ==========================================================
   // field layout
   localparam int TEMP_BITS = 11;
   localparam int LIMIT_BITS = 9;
   localparam int TEMP_PAD_BITS = 5;
   localparam int LIMIT_PAD_BITS = 7;
   localparam int LIMIT_FRAC_BITS = 2;
   localparam int SETUP_SHUTDOWN_BIT = 0;
   localparam int SETUP_LATCH_BIT = 1;
   localparam int SETUP_LEVEL_BIT = 2;
   localparam int SETUP_QUEUE_LSB = 3;
   localparam int SETUP_QUEUE_MSB = 4;

   // ==========================================================
   // reset values
   localparam logic [7:0] SETUP_RESET = 8'h00;
   localparam logic [10:0] TEMP_RESET = 11'h000;
   localparam logic [8:0] HYST_RESET = 9'h096;
   localparam logic [8:0] OVER_RESET = 9'h0A0;
   localparam logic [2:0] QUEUE_COUNT_MAX = 3'h5;

   // ==========================================================
   // conversion sequencer states
   typedef enum logic [1:0] {
      SEQ_WAIT = 2'b01,
      SEQ_BUSY = 2'b10
   } seq_state_t;

   function automatic logic [2:0] queue_depth(input logic [1:0] code);
      logic [2:0] depth;
      depth = 3'h1;
      unique case (code)
         2'h0: depth = 3'h1;
         2'h1: depth = 3'h2;
         2'h2: depth = 3'h4;
         2'h3: depth = 3'h6;
      endcase
      return depth;
   endfunction

endpackage

// File: hdl/thermal_watchdog.sv
// Notes on behaviour
// - temperature held as 11-bit signed eighths
// - result refreshed per conversion, writes ignored
// - result read returns all sixteen bits
// - five lowest result bits read zero
// - hysteresis limit: 9-bit signed half degrees
// - overheat limit: 9-bit signed half degrees
// - each fresh result compared with hysteresis
// - each fresh result compared with overheat
// - open-drain alarm active beyond limits
// - 8-bit read/write setup register
// - bits 4:3 pick trip count 1,2,4,6
// - bit 2 picks alarm active level
// - bit 1 picks interrupt or comparator
// - bit 0 selects shutdown
// - bits 7:5 reserved, read/write, reset zero
// - three strap inputs in bus address
module thermal_watchdog #(
   parameter int unsigned CONV_CYCLES = thermal_pkg::CONV_PERIOD_CYCLES,
   // arbitrary neutral value for the fixed address bits
   parameter logic [3:0] ADDR_HIGH = 4'h5
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [2:0] addr_select,
   output logic [6:0] bus_address,
   input wire logic [1:0] reg_ptr,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   output logic conv_start,
   input wire logic adc_done,
   input wire logic [thermal_pkg::TEMP_BITS-1:0] adc_result,
   output logic alarm_output_o,
   output logic alarm_output_oe,
   output logic alarm_active
);
   import thermal_pkg::*;

   // ==========================================================
   // state
   // signed eighths result
   logic [TEMP_BITS-1:0] temp_reg;
   logic [LIMIT_BITS-1:0] hyst_reg;
   logic [LIMIT_BITS-1:0] over_reg;
   logic [7:0] setup_reg;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic rvalid_reg;
   logic irq_reg;
   logic irq_next;
   logic oe_reg;
   logic oe_next;
   logic [6:0] addr_reg;
   logic strap_done_reg;
   logic conv_done;

   alarm_if alarm ();

   // ==========================================================
   // setup fields
   wire shutdown = setup_reg[SETUP_SHUTDOWN_BIT];
   wire latch_mode = setup_reg[SETUP_LATCH_BIT];
   wire active_high = setup_reg[SETUP_LEVEL_BIT];
   wire [1:0] trip_code = setup_reg[SETUP_QUEUE_MSB:SETUP_QUEUE_LSB];

   // ==========================================================
   // register decode
   wire wr_hyst = reg_wr && (reg_ptr == PTR_HYST);
   wire wr_over = reg_wr && (reg_ptr == PTR_OVER);
   wire wr_setup = reg_wr && (reg_ptr == PTR_SETUP);

   // ==========================================================
   // conversion timing
   // shutdown gates launch
   conv_sequencer #(
      .PERIOD_CYCLES(CONV_CYCLES)
   ) u_seq (
      .clk(clk),
      .resetn(resetn),
      .shutdown(shutdown),
      .adc_done(adc_done),
      .conv_start(conv_start),
      .conv_done(conv_done)
   );

   // ==========================================================
   // limit comparison
   // limits carry two fewer fraction bits than the result
   wire [TEMP_BITS-1:0] over_wide = {over_reg, 2'b00};
   wire [TEMP_BITS-1:0] hyst_wide = {hyst_reg, 2'b00};
   wire over_hit = $signed(adc_result) > $signed(over_wide);
   wire under_hit = $signed(adc_result) < $signed(hyst_wide);

   assign alarm.sample = conv_done;
   assign alarm.over_limit = over_hit;
   assign alarm.under_limit = under_hit;
   assign alarm.depth_code = trip_code;

   alarm_queue u_queue (
      .clk(clk),
      .resetn(resetn),
      .link(alarm)
   );

   // ==========================================================
   // result register
   // refresh on conversion
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         temp_reg <= TEMP_RESET;
      end else if (conv_done) begin
         temp_reg <= adc_result;
      end
   end

   // ==========================================================
   // limit and setup registers
   // hysteresis in half degrees
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hyst_reg <= HYST_RESET;
      end else if (wr_hyst) begin
         hyst_reg <= reg_wdata[15 -: LIMIT_BITS];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         over_reg <= OVER_RESET;
      end else if (wr_over) begin
         over_reg <= reg_wdata[15 -: LIMIT_BITS];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         setup_reg <= SETUP_RESET;
      end else if (wr_setup) begin
         setup_reg <= reg_wdata[7:0];
      end
   end

   // ==========================================================
   // read path
   // whole word latched in one edge so both bytes agree
   // low five result bits read zero; limits read seven low zero bits
   wire [15:0] temp_word = {temp_reg, {TEMP_PAD_BITS{1'b0}}};
   wire [15:0] hyst_word = {hyst_reg, {LIMIT_PAD_BITS{1'b0}}};
   wire [15:0] over_word = {over_reg, {LIMIT_PAD_BITS{1'b0}}};
   wire [15:0] setup_word = {8'h00, setup_reg};

   always_comb begin
      rdata_next = rdata_reg;
      if (reg_rd) begin
         unique case (reg_ptr)
            PTR_TEMP: rdata_next = temp_word;
            PTR_SETUP: rdata_next = setup_word;
            PTR_HYST: rdata_next = hyst_word;
            PTR_OVER: rdata_next = over_word;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= 16'h0000;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rvalid_reg <= reg_rd;
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_rvalid = rvalid_reg;

   // ==========================================================
   // alarm output
   // read clears, new event wins
   assign irq_next = latch_mode &&
                     (alarm.changed || (irq_reg && !reg_rd));
   wire active_next = latch_mode ? irq_next : alarm.tripped;
   assign oe_next = active_high ? !active_next : active_next;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
         oe_reg <= oe_next;
      end
   end

   assign alarm_output_o = 1'b0;
   assign alarm_output_oe = oe_reg;
   assign alarm_active = active_high ? !oe_reg : oe_reg;

   // ==========================================================
   // address straps
   // straps caught after reset release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         addr_reg <= 7'h00;
         strap_done_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         addr_reg <= {ADDR_HIGH, addr_select};
         strap_done_reg <= 1'b1;
      end
   end

   assign bus_address = addr_reg;

   // ==========================================================
   // checks
   AST_TEMP_CAPTURE: assert property (
      @(posedge clk) disable iff (!resetn)
      conv_done |=> temp_reg == $past(adc_result))
      else $error("result not captured at conversion end");

   AST_TEMP_READ_ONLY: assert property (
      @(posedge clk) disable iff (!resetn)
      !conv_done |=> $stable(temp_reg))
      else $error("result changed without a conversion");

   AST_TEMP_WORD: assert property (
      @(posedge clk) disable iff (!resetn)
      (reg_rd && reg_ptr == PTR_TEMP) |=>
         reg_rvalid && reg_rdata[15:5] == $past(temp_reg))
      else $error("result read returned wrong word");

   AST_TEMP_LOW_ZERO: assert property (
      @(posedge clk) disable iff (!resetn)
      (reg_rd && reg_ptr == PTR_TEMP) |=> reg_rdata[4:0] == 5'h00)
      else $error("result low bits not zero");

   AST_HYST_WRITE: assert property (
      @(posedge clk) disable iff (!resetn)
      wr_hyst ##1 !wr_hyst ##1 (reg_rd && reg_ptr == PTR_HYST) |=>
         reg_rdata == {$past(reg_wdata[15:7], 3), 7'h00})
      else $error("hysteresis limit readback wrong");

   AST_OVER_WRITE: assert property (
      @(posedge clk) disable iff (!resetn)
      wr_over |=> over_reg == $past(reg_wdata[15:7]))
      else $error("overheat limit not written");

   AST_SETUP_READBACK: assert property (
      @(posedge clk) disable iff (!resetn)
      (reg_rd && reg_ptr == PTR_SETUP) |=>
         reg_rdata == {8'h00, $past(setup_reg)})
      else $error("setup readback wrong");

   AST_IRQ_CLEAR: assert property (
      @(posedge clk) disable iff (!resetn)
      (latch_mode && irq_reg && reg_rd && !alarm.changed) |=> !irq_reg)
      else $error("read did not clear latched alarm");

   AST_PIN_LEVEL: assert property (
      @(posedge clk) disable iff (!resetn)
      !latch_mode && !$changed(setup_reg) && !$changed(alarm.tripped)
      |=> alarm_output_oe == ($past(active_high) ^ $past(alarm.tripped)))
      else $error("alarm pin level does not follow polarity");

   AST_RESULT_NO_WRITE: assert property (
      @(posedge clk) disable iff (!resetn)
      (reg_wr && reg_ptr == PTR_TEMP && !conv_done) |=> $stable(temp_reg))
      else $error("result register took a bus write");

   AST_RVALID_ANSWER: assert property (
      @(posedge clk) disable iff (!resetn)
      reg_rd |=> reg_rvalid)
      else $error("read not answered in the next cycle");

   AST_RVALID_IDLE: assert property (
      @(posedge clk) disable iff (!resetn)
      !reg_rd |=> !reg_rvalid)
      else $error("read valid without a read");

   AST_RDATA_HOLD: assert property (
      @(posedge clk) disable iff (!resetn)
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");

   AST_SETUP_WRITE: assert property (
      @(posedge clk) disable iff (!resetn)
      wr_setup |=> setup_reg == $past(reg_wdata[7:0]))
      else $error("setup byte not written");

   AST_SETUP_HOLD: assert property (
      @(posedge clk) disable iff (!resetn)
      !wr_setup |=> $stable(setup_reg))
      else $error("setup changed without a write");

   AST_HYST_HOLD: assert property (
      @(posedge clk) disable iff (!resetn)
      !wr_hyst |=> $stable(hyst_reg))
      else $error("hysteresis limit changed without a write");

   AST_OVER_HOLD: assert property (
      @(posedge clk) disable iff (!resetn)
      !wr_over |=> $stable(over_reg))
      else $error("overheat limit changed without a write");

   AST_STRAP_CAPTURE: assert property (
      @(posedge clk) disable iff (!resetn)
      !strap_done_reg |=> bus_address == {ADDR_HIGH, $past(addr_select)})
      else $error("bus address not taken from the straps");

   AST_STRAP_HOLD: assert property (
      @(posedge clk) disable iff (!resetn)
      strap_done_reg |=> $stable(bus_address))
      else $error("bus address moved after capture");

   AST_IRQ_SET: assert property (
      @(posedge clk) disable iff (!resetn)
      (latch_mode && alarm.changed) |=> irq_reg)
      else $error("queue change not latched in interrupt mode");

   AST_IRQ_IDLE: assert property (
      @(posedge clk) disable iff (!resetn)
      !latch_mode |=> !irq_reg)
      else $error("latched alarm set in comparator mode");

   AST_OVER_TRIP: assert property (
      @(posedge clk) disable iff (!resetn)
      (conv_done && !alarm.tripped && trip_code == 2'h0 &&
       $signed(adc_result) > $signed({over_reg, 2'b00})) |=>
         alarm.tripped)
      else $error("single over-limit result did not trip");

   AST_UNDER_RELEASE: assert property (
      @(posedge clk) disable iff (!resetn)
      (conv_done && alarm.tripped && trip_code == 2'h0 &&
       $signed(adc_result) < $signed({hyst_reg, 2'b00})) |=>
         !alarm.tripped)
      else $error("single under-limit result did not release");
endmodule
